/* File: hw/sync_align_consts.svh */
// register offsets, field positions and reset values of the sync and fifo alignment block
`ifndef SYNC_ALIGN_CONSTS_SVH
`define SYNC_ALIGN_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SA_OFF_CTRL 8'h10
`define SA_OFF_PREQ 8'h11
`define SA_OFF_LSTAT 8'h12
`define SA_OFF_PMEAS 8'h13
`define SA_OFF_FOFS 8'h17
`define SA_OFF_FSTAT 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SA_BIT_EN 7
`define SA_BIT_RATE 6
`define SA_BIT_EDGE 3
`define SA_BIT_LOST 7
`define SA_BIT_LOCKED 6
`define SA_BIT_WARN1 7
`define SA_BIT_WARN2 6
`define SA_BIT_ACK 2
`define SA_BIT_SREQ 1
`define SA_BIT_HWAL 0

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SA_RST_CTRL 8'h48
`define SA_RST_PREQ 6'h00
`define SA_RST_FOFS 3'h4
`define SA_FIFO_RATE_DIV 8

`endif

/* File: hw/sync_align_pkg.sv */
// types shared by the sync and fifo alignment block
package sync_align_pkg;
    // register data byte
    typedef logic [7:0] byte_t;
    // fifo pointer
    typedef logic [2:0] ptr_t;
    // sync lock states
    typedef enum logic [1:0] {
        SYNC_OFF,
        SYNC_SEEK,
        SYNC_LOCKED,
        SYNC_LOST
    } sync_state_t;
endpackage

/* File: hw/fifo_ptr_align.sv */
// fifo read and write pointers with offset reset, proximity warnings and align flags
`timescale 1ns/1ps
module fifo_ptr_align #(
    parameter int PTR_W = 3
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic hw_rst_i,        // pointer reset from power-up or sync
    input wire logic soft_rst_i,      // pointer reset requested by software
    input wire logic soft_clr_i,      // software withdrew its request
    input wire logic [PTR_W-1:0] offset_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic warn1_o,
    output logic warn2_o,
    output logic hw_aligned_o,
    output logic soft_ack_o
);
    // ----------------------------------------------------------------
    // pointers
    // ----------------------------------------------------------------
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    wire any_rst_w = hw_rst_i | soft_rst_i;
    wire [PTR_W-1:0] wr_nxt_w = wr_ptr_q + PTR_W'(wr_en_i);
    wire [PTR_W-1:0] rd_nxt_w = rd_ptr_q + PTR_W'(rd_en_i);

    // circular distance between two pointers, the shorter way round
    function automatic logic [PTR_W-1:0] ptr_dist(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b);
        logic [PTR_W-1:0] d;
        d = a - b;
        ptr_dist = d[PTR_W-1] ? PTR_W'(b - a) : d;
    endfunction

    wire [PTR_W-1:0] dist_w = ptr_dist(wr_nxt_w, rd_nxt_w);

    // pointer reset puts the write pointer ahead by the offset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (any_rst_w) begin
            wr_ptr_q <= offset_i;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_nxt_w;
            rd_ptr_q <= rd_nxt_w;
        end
    end

    // ----------------------------------------------------------------
    // warnings and align flags
    // ----------------------------------------------------------------
    // warnings are live levels; built from the next pointers, they change in the same cycle as the pointers, except a pointer reset clears them for that cycle
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warn1_o <= 1'b0;
            warn2_o <= 1'b0;
            hw_aligned_o <= 1'b0;
            soft_ack_o <= 1'b0;
        end else begin
            warn1_o <= !any_rst_w && (dist_w <= PTR_W'(1));
            warn2_o <= !any_rst_w && (dist_w <= PTR_W'(2));
            if (hw_rst_i) begin
                hw_aligned_o <= 1'b1;
            end
            // set wins so an ack is never lost to a late clear
            if (soft_rst_i) begin
                soft_ack_o <= 1'b1;
            end else if (soft_clr_i) begin
                soft_ack_o <= 1'b0;
            end
        end
    end

    property p_ptr_offset;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        any_rst_w |=> (PTR_W'(wr_ptr_q - rd_ptr_q) == $past(offset_i));
    endproperty
    a_ptr_offset: assert property (p_ptr_offset) else $error("write pointer not ahead by offset");

    property p_warn1;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !any_rst_w |=> (warn1_o == (ptr_dist(wr_ptr_q, rd_ptr_q) <= PTR_W'(1)));
    endproperty
    a_warn1: assert property (p_warn1) else $error("near warning does not match pointers");

    property p_soft_ack;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        soft_rst_i |=> soft_ack_o && (wr_ptr_q == $past(offset_i));
    endproperty
    a_soft_ack: assert property (p_soft_ack) else $error("soft align not acknowledged");
endmodule

/* File: hw/sync_align.sv */
// multichip sync alignment: sync edge capture, phase averaging, lock tracking and registers
`timescale 1ns/1ps
`include "sync_align_consts.svh"
module sync_align #(
    parameter int FIFO_RATE_DIV = `SA_FIFO_RATE_DIV
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic sync_i,                 // external sync pin
    input wire logic fifo_wr_i,              // fifo write strobe, same clock
    input wire logic fifo_rd_i,              // fifo read strobe, same clock
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire sync_align_pkg::byte_t reg_wdata_i,
    output sync_align_pkg::byte_t reg_rdata_o,
    output logic [5:0] out_phase_o,          // output timing counter
    output logic sync_locked_o
);
    import sync_align_pkg::*;

    // ----------------------------------------------------------------
    // registers written by software
    // ----------------------------------------------------------------
    byte_t ctrl_q;                 // enable, rate, edge, averaging
    logic [5:0] preq_q;            // requested phase
    ptr_t fofs_q;                  // fifo pointer offset
    logic sreq_q;                  // soft align request bit

    wire wr_ctrl_w = reg_wr_i && (reg_addr_i == `SA_OFF_CTRL);
    wire wr_preq_w = reg_wr_i && (reg_addr_i == `SA_OFF_PREQ);
    wire wr_fofs_w = reg_wr_i && (reg_addr_i == `SA_OFF_FOFS);
    wire wr_fstat_w = reg_wr_i && (reg_addr_i == `SA_OFF_FSTAT);

    wire sync_en_w = ctrl_q[`SA_BIT_EN];
    wire rate_w = ctrl_q[`SA_BIT_RATE];
    wire edge_sel_w = ctrl_q[`SA_BIT_EDGE];
    wire [2:0] avg_w = ctrl_q[2:0];

    // unused control bits are kept out so they read as zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= `SA_RST_CTRL;
            preq_q <= `SA_RST_PREQ;
            fofs_q <= `SA_RST_FOFS;
            sreq_q <= 1'b0;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= reg_wdata_i & 8'hcf;
            end
            if (wr_preq_w) begin
                preq_q <= reg_wdata_i[5:0];
            end
            if (wr_fofs_w) begin
                fofs_q <= reg_wdata_i[2:0];
            end
            if (wr_fstat_w) begin
                sreq_q <= reg_wdata_i[`SA_BIT_SREQ];
            end
        end
    end

    // ----------------------------------------------------------------
    // sync pin capture
    // ----------------------------------------------------------------
    logic sync_meta_q;             // first stage, read only by the second
    logic sync_s_q;                // synchronised level
    logic sync_d_q;                // previous level for edge detect

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_meta_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_d_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_i;
            sync_s_q <= sync_meta_q;
            sync_d_q <= sync_s_q;
        end
    end

    wire rise_w = sync_s_q && !sync_d_q;
    wire fall_w = !sync_s_q && sync_d_q;
    // chosen edge of the sync input
    wire edge_w = edge_sel_w ? rise_w : fall_w;

    // ----------------------------------------------------------------
    // cadence: every edge at data rate, one in FIFO_RATE_DIV at fifo rate
    // ----------------------------------------------------------------
    logic [7:0] rate_cnt_q;
    wire rate_hit_w = (rate_cnt_q == 8'h00);
    wire take_w = sync_en_w && edge_w && (rate_w || rate_hit_w);
    // fifo-rate sync also realigns the fifo pointers
    wire sync_frst_w = take_w && !rate_w;

    // divider of sync edges, restarted while disabled
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rate_cnt_q <= 8'h00;
        end else if (!sync_en_w) begin
            rate_cnt_q <= 8'h00;
        end else if (edge_w) begin
            rate_cnt_q <= (rate_cnt_q == 8'(FIFO_RATE_DIV - 1)) ? 8'h00 : rate_cnt_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // phase averaging
    // ----------------------------------------------------------------
    // number of samples for an averaging code
    function automatic logic [7:0] pow2(input logic [2:0] code);
        pow2 = 8'h01 << code;
    endfunction

    logic [5:0] out_cnt_q;         // output timing counter, period 64
    logic [6:0] smp_cnt_q;         // samples taken in this set
    logic [12:0] sum_q;            // sum of samples, 128 x 63 fits
    byte_t phase_avg_q;            // averaged phase, 6.2

    wire [12:0] sum_nxt_w = sum_q + {7'h00, out_cnt_q};
    wire [14:0] sum4_w = {sum_nxt_w, 2'b00};
    wire [14:0] mean_full_w = sum4_w >> avg_w;
    // quarter-cycle resolution comes from the two extra low bits
    wire [7:0] mean_w = mean_full_w[7:0];
    wire set_done_w = take_w && ({1'b0, smp_cnt_q} == (pow2(avg_w) - 8'h01));
    wire match_w = (mean_w == {preq_q, 2'b00});
    wire [5:0] delta_w = preq_q - mean_w[7:2];
    // a mismatched set steps the output timing onto the request
    wire adjust_w = set_done_w && !match_w;

    // samples are the timing counter seen at each taken sync edge
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            smp_cnt_q <= 7'h00;
            sum_q <= 13'h0000;
        end else if (!sync_en_w || set_done_w) begin
            smp_cnt_q <= 7'h00;
            sum_q <= 13'h0000;
        end else if (take_w) begin
            smp_cnt_q <= smp_cnt_q + 7'h01;
            sum_q <= sum_nxt_w;
        end
    end

    // readback moves only when a whole set is in
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_avg_q <= 8'h00;
        end else if (set_done_w) begin
            phase_avg_q <= mean_w;
        end
    end

    // free running, shifted by the phase error after a bad set
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_cnt_q <= 6'h00;
        end else if (adjust_w) begin
            out_cnt_q <= out_cnt_q + 6'h01 + delta_w;
        end else begin
            out_cnt_q <= out_cnt_q + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // lock tracking
    // ----------------------------------------------------------------
    sync_state_t state_q;
    sync_state_t state_d;
    logic lost_q;                  // sticky until sync is disabled

    // next lock state; enable leaves off and disable forces off, otherwise only a finished set may change it
    always_comb begin
        state_d = state_q;
        case (state_q)
            SYNC_OFF: begin
                if (sync_en_w) begin
                    state_d = SYNC_SEEK;
                end
            end
            SYNC_SEEK, SYNC_LOST: begin
                if (set_done_w && match_w) begin
                    state_d = SYNC_LOCKED;
                end
            end
            SYNC_LOCKED: begin
                if (set_done_w && !match_w) begin
                    state_d = SYNC_LOST;
                end
            end
            default: begin
                state_d = SYNC_OFF;
            end
        endcase
        if (!sync_en_w) begin
            state_d = SYNC_OFF;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SYNC_OFF;
            lost_q <= 1'b0;
            sync_locked_o <= 1'b0;
        end else begin
            state_q <= state_d;
            sync_locked_o <= (state_d == SYNC_LOCKED);
            if (state_d == SYNC_LOST) begin
                lost_q <= 1'b1;
            end else if (state_d == SYNC_OFF) begin
                lost_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // fifo pointers
    // ----------------------------------------------------------------
    logic por_q;                   // one pointer reset after hardware reset
    wire sreq_rise_w = wr_fstat_w && reg_wdata_i[`SA_BIT_SREQ] && !sreq_q;
    wire sreq_clr_w = wr_fstat_w && !reg_wdata_i[`SA_BIT_SREQ];
    wire warn1_w;
    wire warn2_w;
    wire hw_al_w;
    wire ack_w;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_q <= 1'b1;
        end else begin
            por_q <= 1'b0;
        end
    end

    fifo_ptr_align #(
        .PTR_W(3)
    ) i_fifo_ptr_align (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .hw_rst_i(por_q | sync_frst_w),
        .soft_rst_i(sreq_rise_w),
        .soft_clr_i(sreq_clr_w),
        .offset_i(fofs_q),
        .wr_en_i(fifo_wr_i),
        .rd_en_i(fifo_rd_i),
        .warn1_o(warn1_w),
        .warn2_o(warn2_w),
        .hw_aligned_o(hw_al_w),
        .soft_ack_o(ack_w)
    );

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    wire [7:0] lstat_w = {lost_q, sync_locked_o, 6'h00};
    wire [7:0] fstat_w = {warn1_w, warn2_w, 3'h0, ack_w, sreq_q, hw_al_w};
    // unmapped offsets read as zero
    wire [7:0] rmux_w = (reg_addr_i == `SA_OFF_CTRL) ? ctrl_q :
                        (reg_addr_i == `SA_OFF_PREQ) ? {2'b00, preq_q} :
                        (reg_addr_i == `SA_OFF_LSTAT) ? lstat_w :
                        (reg_addr_i == `SA_OFF_PMEAS) ? phase_avg_q :
                        (reg_addr_i == `SA_OFF_FOFS) ? {5'h00, fofs_q} :
                        (reg_addr_i == `SA_OFF_FSTAT) ? fstat_w : 8'h00;

    // read data is held until the next read strobe
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
            out_phase_o <= 6'h00;
        end else begin
            out_phase_o <= out_cnt_q;
            if (reg_rd_i) begin
                reg_rdata_o <= rmux_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_off_no_take;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !sync_en_w |=> (state_q == SYNC_OFF) && (smp_cnt_q == 7'h00);
    endproperty
    a_off_no_take: assert property (p_off_no_take) else $error("sync active while disabled");
    property p_fifo_rate;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (sync_en_w && !rate_w && edge_w && !rate_hit_w) |-> !take_w;
    endproperty
    a_fifo_rate: assert property (p_fifo_rate) else $error("edge taken off fifo cadence");
    property p_edge_sel;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        take_w |-> (edge_sel_w ? (sync_s_q && !sync_d_q) : (!sync_s_q && sync_d_q));
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("wrong sync edge taken");
    property p_set_size;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        set_done_w |-> (8'(smp_cnt_q) + 8'h01 == pow2(avg_w));
    endproperty
    a_set_size: assert property (p_set_size) else $error("set size differs from averaging code");
    property p_phase_step;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        adjust_w |=> (out_cnt_q == 6'($past(out_cnt_q) + 6'h01 + $past(delta_w)));
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("output timing not moved onto request");
    property p_lost;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (state_q == SYNC_LOCKED && set_done_w && !match_w && sync_en_w) |=> lost_q && !sync_locked_o;
    endproperty
    a_lost: assert property (p_lost) else $error("lost lock not flagged");
    property p_locked;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (sync_en_w && set_done_w && match_w && state_q != SYNC_OFF) |=> sync_locked_o;
    endproperty
    a_locked: assert property (p_locked) else $error("match not reported as locked");
    property p_avg_hold;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !set_done_w |=> $stable(phase_avg_q);
    endproperty
    a_avg_hold: assert property (p_avg_hold) else $error("readback moved inside a set");
    property p_avg_value;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        set_done_w |=> (phase_avg_q == $past(mean_w)) && (phase_avg_q[7:2] <= 6'h3f);
    endproperty
    a_avg_value: assert property (p_avg_value) else $error("readback is not the set mean");
endmodule

/* File: bench/sync_source.sv */
// behavioural model of the shared external sync pulse source
`timescale 1ns/1ps
module sync_source (
    input wire logic sys_clk_i,
    input wire logic run_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] width_i,
    output logic sync_o
);
    // ----------------------------------------------------------------
    // pulse generator
    // ----------------------------------------------------------------
    logic [7:0] cnt_q; // position inside the sync period
    initial begin
        cnt_q = 8'h00;
        sync_o = 1'b0;
    end
    // periodic pulse, stands low while stopped so no stray edge is seen
    always @(posedge sys_clk_i) begin
        #1;
        if (!run_i) begin
            cnt_q = 8'h00;
            sync_o = 1'b0;
        end else begin
            sync_o = (cnt_q < width_i);
            cnt_q = (cnt_q == period_i - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        end
    end
endmodule

/* File: bench/tb_sync_align.sv */
// self-checking testbench of the sync and fifo alignment block
`timescale 1ns/1ps
module tb_sync_align;
    import sync_align_pkg::*;
    // ----------------------------------------------------------------
    // stimulus signals
    // ----------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sync_w; // pin driven by the pulse model
    logic fifo_wr_i = 1'b0;
    logic fifo_rd_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    byte_t reg_wdata_i = 8'h00;
    byte_t reg_rdata_o;
    logic [5:0] out_phase_o;
    logic sync_locked_o;
    logic run = 1'b0; // pulse source running
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // small fifo-rate divider keeps the cadence test short
    sync_align #(.FIFO_RATE_DIV(2)) i_sync_align (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sync_i(sync_w),
        .fifo_wr_i(fifo_wr_i), .fifo_rd_i(fifo_rd_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .out_phase_o(out_phase_o), .sync_locked_o(sync_locked_o)
    );
    // period of 64 lets a locked counter stay locked
    sync_source i_sync_source (
        .sys_clk_i(sys_clk_i), .run_i(run), .period_i(8'h40), .width_i(8'h05), .sync_o(sync_w)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input byte_t got, input byte_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, released a cycle later
    task automatic wr(input logic [7:0] a, input byte_t d);
        @(posedge sys_clk_i) #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge sys_clk_i) #1;
        reg_wr_i = 1'b0;
    endtask
    // read data is settled just after the edge that follows the strobe
    task automatic rd(input logic [7:0] a, input byte_t exp);
        @(posedge sys_clk_i) #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge sys_clk_i) #1;
        reg_rd_i = 1'b0;
        check(reg_rdata_o, exp);
    endtask
    task automatic pulse(input logic w, input logic r);
        @(posedge sys_clk_i) #1;
        fifo_wr_i = w;
        fifo_rd_i = r;
        @(posedge sys_clk_i) #1;
        fifo_wr_i = 1'b0;
        fifo_rd_i = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(8'h10, 8'h48);
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h00);
        rd(8'h17, 8'h04);
        rd(8'h18, 8'h01);
        rd(8'h20, 8'h00);
    endtask
    task automatic t_regs();
        wr(8'h11, 8'hff);
        rd(8'h11, 8'h3f);
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h00);
        wr(8'h13, 8'h55);
        rd(8'h13, 8'h00);
        wr(8'h10, 8'h37);
        rd(8'h10, 8'h07);
    endtask
    // soft align with offset 2, then narrow the gap to one
    task automatic t_fifo();
        wr(8'h17, 8'h02);
        wr(8'h18, 8'h02);
        rd(8'h18, 8'h47);
        pulse(1'b1, 1'b1);
        rd(8'h18, 8'h47);
        pulse(1'b0, 1'b1);
        rd(8'h18, 8'hc7);
        wr(8'h18, 8'h00);
        rd(8'h18, 8'hc1);
    endtask
    // fifo-rate sync take must realign the pointers to the new offset
    task automatic t_fiforate();
        wr(8'h17, 8'h04);
        run = 1'b1;
        wr(8'h10, 8'h88);
        idle(200);
        rd(8'h18, 8'h01);
        wr(8'h10, 8'h48);
        run = 1'b0;
    endtask
    task automatic t_lock();
        int n;
        wr(8'h11, 8'h2a);
        idle(300);
        check({7'h00, sync_locked_o}, 8'h00);
        run = 1'b1;
        wr(8'h10, 8'hca);
        n = 0;
        while (sync_locked_o !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        idle(2);
        check({7'h00, sync_locked_o}, 8'h01);
        rd(8'h13, 8'ha8);
        rd(8'h12, 8'h40);
        // a locked rising edge is taken two edges after the pin; the output copy shows the request one edge later
        @(posedge sync_w);
        repeat (3) @(posedge sys_clk_i);
        #1;
        check({2'b00, out_phase_o}, 8'h2a);
        // falling edge comes five cycles later, so the phase breaks then relocks
        wr(8'h10, 8'hc2);
        idle(1500);
        rd(8'h12, 8'hc0);
        rd(8'h13, 8'ha8);
        wr(8'h10, 8'h42);
        idle(300);
        rd(8'h12, 8'h00);
        check({7'h00, sync_locked_o}, 8'h00);
        run = 1'b0;
    endtask
    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        idle(5);
        rstn_i = 1'b1;
        t_reset();
        t_regs();
        t_fifo();
        t_fiforate();
        t_lock();
        results();
    end
    // ceiling well above the few thousand cycles the run needs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
endmodule
